//--- hw/spm_defs.vh
`ifndef SPM_DEFS_VH
`define SPM_DEFS_VH

// register port
`define SPM_ADDR_W        8
`define SPM_SEL_OFS       8'h00
`define SPM_STAT_OFS      8'h01

// external_bus_selection layout
`define SPM_SEL_RESET     16'h0000
`define SPM_SEL_WMASK     16'h7f3f
`define SPM_PP_HI         14
`define SPM_PP_LO         12
`define SPM_SP1_HI        11
`define SPM_SP1_LO        10
`define SPM_SP0_HI        9
`define SPM_SP0_LO        8
`define SPM_ADDR_HI       5
`define SPM_ADDR_LO       0

// serial port group modes
`define SPM_SP_CARD       2'h0
`define SPM_SP_AUDIO      2'h1
`define SPM_SP_GPIO       2'h2

// parallel port modes handled here
`define SPM_PP_DISP       3'h0
`define SPM_PP_MIXED      3'h1

// remap_status layout, write one to clear
`define SPM_STAT_RESET    4'h0
`define SPM_ST_PP         0
`define SPM_ST_SP0        1
`define SPM_ST_SP1        2
`define SPM_ST_ADDR       3

// gpio line bases per pin group
`define SPM_GP_SP0_BASE   0
`define SPM_GP_SP1_BASE   6
`define SPM_GP_PP_BASE    12
`define SPM_GP_ADDR_BASE  21

`endif

//--- hw/spm_serial_port.v
`timescale 1ns/1ns
`include "spm_defs.vh"

// one six-pin serial port group: card port, audio port plus two gpio, or six gpio
module spm_serial_port (
    input  wire [1:0] sel,
    input  wire [5:0] card_out,
    input  wire [5:0] card_oe_n,
    output reg  [5:0] card_in,
    input  wire [3:0] aud_out,
    input  wire [3:0] aud_oe_n,
    output reg  [3:0] aud_in,
    input  wire [5:0] gpio_out,
    input  wire [5:0] gpio_oe_n,
    output reg  [5:0] gpio_in,
    input  wire [5:0] pin_in,
    output reg  [5:0] pin_out,
    output reg  [5:0] pin_oe_n
);

    always @* begin
        card_in  = 6'h00;
        aud_in   = 4'h0;
        gpio_in  = 6'h00;
        pin_out  = 6'h00;
        pin_oe_n = 6'h3f;
        case (sel)
            `SPM_SP_CARD: begin
                pin_out  = card_out;
                pin_oe_n = card_oe_n;
                card_in  = pin_in;
            end
            `SPM_SP_AUDIO: begin
                pin_out  = {gpio_out[5:4], aud_out};
                pin_oe_n = {gpio_oe_n[5:4], aud_oe_n};
                aud_in   = pin_in[3:0];
                gpio_in  = {pin_in[5:4], 4'h0};
            end
            `SPM_SP_GPIO: begin
                pin_out  = gpio_out;
                pin_oe_n = gpio_oe_n;
                gpio_in  = pin_in;
            end
            // reserved code: pins released, every input held low
            default: begin
                pin_out  = 6'h00;
                pin_oe_n = 6'h3f;
            end
        endcase
    end

endmodule

//--- hw/spm_pin_mux.v
// How it works
// - Serial port 1 select 00 puts all six card port 1 signals on the serial port 1 pins.
// - Serial port 1 select 01 puts four audio port 1 signals and gpio 11 and 10 there.
// - Serial port 1 select 10 gives all six pins to gpio 11 down to 6; code 11 is unused.
// - Serial port 0 select 00 puts all six card port 0 signals on the serial port 0 pins.
// - Serial port 0 select 01 puts four audio port 0 signals and gpio 5 and 4 there.
// - Serial port 0 select 10 gives all six pins to gpio 5 down to 0; code 11 is unused.
// - Bits 7 and 6 always read a fixed value and ignore writes.
// - Bit 5 picks memory address line 20 when clear and gpio 26 when set.
// - Bit 4 picks memory address line 19 when clear and gpio 25 when set.
// - Bit 3 picks memory address line 18 when clear and gpio 24 when set.
// - Bit 2 picks memory address line 17 when clear and gpio 23 when set.
// - Bit 1 picks memory address line 16 when clear and gpio 22 when set.
// - Bit 0 picks memory address line 15 when clear and gpio 21 when set.
// - Parallel port select 000 puts all 21 display bridge signals on the parallel pins.
// - Parallel port select 001 shares the pins among spi, gpio, uart and audio port 2.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/1ns
`include "spm_defs.vh"

module spm_pin_mux (
    input  wire                   REF_CLK,
    input  wire                   RSTN,
    input  wire [`SPM_ADDR_W-1:0] REG_ADDR,
    input  wire [15:0]            REG_WDATA,
    input  wire                   REG_WR,
    input  wire                   REG_RD,
    output reg  [15:0]            REG_RDATA,
    input  wire [5:0]             SP1_PIN_IN,
    output wire [5:0]             SP1_PIN_OUT,
    output wire [5:0]             SP1_PIN_OE_N,
    input  wire [5:0]             SP0_PIN_IN,
    output wire [5:0]             SP0_PIN_OUT,
    output wire [5:0]             SP0_PIN_OE_N,
    input  wire [5:0]             CARD_PORT1_OUT,
    input  wire [5:0]             CARD_PORT1_OE_N,
    output wire [5:0]             CARD_PORT1_IN,
    input  wire [5:0]             CARD_PORT0_OUT,
    input  wire [5:0]             CARD_PORT0_OE_N,
    output wire [5:0]             CARD_PORT0_IN,
    input  wire [3:0]             AUDIO_SERIAL_PORT1_OUT,
    input  wire [3:0]             AUDIO_SERIAL_PORT1_OE_N,
    output wire [3:0]             AUDIO_SERIAL_PORT1_IN,
    input  wire [3:0]             AUDIO_SERIAL_PORT0_OUT,
    input  wire [3:0]             AUDIO_SERIAL_PORT0_OE_N,
    output wire [3:0]             AUDIO_SERIAL_PORT0_IN,
    input  wire [5:0]             ADDR_PIN_IN,
    output wire [5:0]             ADDR_PIN_OUT,
    output wire [5:0]             ADDR_PIN_OE_N,
    input  wire [5:0]             EXT_MEMORY_ADDRESS,
    input  wire [20:0]            PP_PIN_IN,
    output reg  [20:0]            PP_PIN_OUT,
    output reg  [20:0]            PP_PIN_OE_N,
    input  wire [20:0]            DISP_OUT,
    input  wire [20:0]            DISP_OE_N,
    output reg  [20:0]            DISP_IN,
    input  wire [6:0]             SPI_OUT,
    input  wire [6:0]             SPI_OE_N,
    output wire [6:0]             SPI_IN,
    input  wire [3:0]             UART_OUT,
    input  wire [3:0]             UART_OE_N,
    output wire [3:0]             UART_IN,
    input  wire [3:0]             AUDIO_SERIAL_PORT2_OUT,
    input  wire [3:0]             AUDIO_SERIAL_PORT2_OE_N,
    output wire [3:0]             AUDIO_SERIAL_PORT2_IN,
    input  wire [31:0]            GENERAL_PURPOSE_IO_LINE_OUT,
    input  wire [31:0]            GENERAL_PURPOSE_IO_LINE_OE_N,
    output wire [31:0]            GENERAL_PURPOSE_IO_LINE_IN
);

    reg  [15:0] external_bus_selection;
    reg  [3:0]  remap_status;
    reg  [15:0] next_external_bus_selection;
    reg  [3:0]  next_remap_status;
    reg  [3:0]  changed;
    reg  [20:0] mix_in;
    wire [20:0] mix_out;
    wire [20:0] mix_oe_n;
    wire        sel_hit;
    wire        stat_hit;
    wire [1:0]  serial_port1_select;
    wire [1:0]  serial_port0_select;
    wire [2:0]  parallel_port_select;
    wire [5:0]  addr_line_select;
    wire [5:0]  sp0_gpio_in;
    wire [5:0]  sp1_gpio_in;
    wire [5:0]  addr_gpio_in;

    assign sel_hit  = (REG_ADDR == `SPM_SEL_OFS);
    assign stat_hit = (REG_ADDR == `SPM_STAT_OFS);

    assign serial_port1_select  = external_bus_selection[`SPM_SP1_HI:`SPM_SP1_LO];
    assign serial_port0_select  = external_bus_selection[`SPM_SP0_HI:`SPM_SP0_LO];
    assign parallel_port_select = external_bus_selection[`SPM_PP_HI:`SPM_PP_LO];
    assign addr_line_select     = external_bus_selection[`SPM_ADDR_HI:`SPM_ADDR_LO];

    // register writes; reserved bits are masked so they keep their reset value
    always @* begin
        next_external_bus_selection = external_bus_selection;
        if (REG_WR && sel_hit) begin
            next_external_bus_selection = (external_bus_selection & ~`SPM_SEL_WMASK)
                                        | (REG_WDATA & `SPM_SEL_WMASK);
        end
    end

    // which pin groups moved on this write, so software knows what to reset
    always @* begin
        changed = 4'h0;
        if (REG_WR && sel_hit) begin
            changed[`SPM_ST_PP]   = next_external_bus_selection[`SPM_PP_HI:`SPM_PP_LO]
                                    != parallel_port_select;
            changed[`SPM_ST_SP0]  = next_external_bus_selection[`SPM_SP0_HI:`SPM_SP0_LO]
                                    != serial_port0_select;
            changed[`SPM_ST_SP1]  = next_external_bus_selection[`SPM_SP1_HI:`SPM_SP1_LO]
                                    != serial_port1_select;
            changed[`SPM_ST_ADDR] = next_external_bus_selection[`SPM_ADDR_HI:`SPM_ADDR_LO]
                                    != addr_line_select;
        end
    end

    // a change in the same cycle as its clear stays set
    always @* begin
        next_remap_status = remap_status;
        if (REG_WR && stat_hit) begin
            next_remap_status = remap_status & ~REG_WDATA[3:0];
        end
        next_remap_status = next_remap_status | changed;
    end

    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            external_bus_selection <= `SPM_SEL_RESET;
            remap_status           <= `SPM_STAT_RESET;
        end else begin
            external_bus_selection <= next_external_bus_selection;
            remap_status           <= next_remap_status;
        end
    end

    // read data stand only in the cycle after the strobe; unmapped reads give zero
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_RDATA <= 16'h0000;
        end else if (REG_RD && sel_hit) begin
            REG_RDATA <= external_bus_selection;
        end else if (REG_RD && stat_hit) begin
            REG_RDATA <= {12'h000, remap_status};
        end else begin
            REG_RDATA <= 16'h0000;
        end
    end

    spm_serial_port u_sp1 (
        .sel       (serial_port1_select),
        .card_out  (CARD_PORT1_OUT),
        .card_oe_n (CARD_PORT1_OE_N),
        .card_in   (CARD_PORT1_IN),
        .aud_out   (AUDIO_SERIAL_PORT1_OUT),
        .aud_oe_n  (AUDIO_SERIAL_PORT1_OE_N),
        .aud_in    (AUDIO_SERIAL_PORT1_IN),
        .gpio_out  (GENERAL_PURPOSE_IO_LINE_OUT[`SPM_GP_SP1_BASE+5:`SPM_GP_SP1_BASE]),
        .gpio_oe_n (GENERAL_PURPOSE_IO_LINE_OE_N[`SPM_GP_SP1_BASE+5:`SPM_GP_SP1_BASE]),
        .gpio_in   (sp1_gpio_in),
        .pin_in    (SP1_PIN_IN),
        .pin_out   (SP1_PIN_OUT),
        .pin_oe_n  (SP1_PIN_OE_N)
    );

    spm_serial_port u_sp0 (
        .sel       (serial_port0_select),
        .card_out  (CARD_PORT0_OUT),
        .card_oe_n (CARD_PORT0_OE_N),
        .card_in   (CARD_PORT0_IN),
        .aud_out   (AUDIO_SERIAL_PORT0_OUT),
        .aud_oe_n  (AUDIO_SERIAL_PORT0_OE_N),
        .aud_in    (AUDIO_SERIAL_PORT0_IN),
        .gpio_out  (GENERAL_PURPOSE_IO_LINE_OUT[`SPM_GP_SP0_BASE+5:`SPM_GP_SP0_BASE]),
        .gpio_oe_n (GENERAL_PURPOSE_IO_LINE_OE_N[`SPM_GP_SP0_BASE+5:`SPM_GP_SP0_BASE]),
        .gpio_in   (sp0_gpio_in),
        .pin_in    (SP0_PIN_IN),
        .pin_out   (SP0_PIN_OUT),
        .pin_oe_n  (SP0_PIN_OE_N)
    );

    // address pins: the memory interface drives them whenever selected
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_addr
            assign ADDR_PIN_OUT[i]  = addr_line_select[i]
                                    ? GENERAL_PURPOSE_IO_LINE_OUT[`SPM_GP_ADDR_BASE+i]
                                    : EXT_MEMORY_ADDRESS[i];
            assign ADDR_PIN_OE_N[i] = addr_line_select[i]
                                    ? GENERAL_PURPOSE_IO_LINE_OE_N[`SPM_GP_ADDR_BASE+i]
                                    : 1'b0;
            assign addr_gpio_in[i]  = addr_line_select[i] & ADDR_PIN_IN[i];
        end
    endgenerate

    // mixed parallel mode in pin order: spi clk/rx/tx, gpio 12..17,
    // audio port 2, uart, spi chip selects 0..3
    assign mix_out  = {SPI_OUT[6:3], UART_OUT, AUDIO_SERIAL_PORT2_OUT,
                       GENERAL_PURPOSE_IO_LINE_OUT[`SPM_GP_PP_BASE+5:`SPM_GP_PP_BASE],
                       SPI_OUT[2:0]};
    assign mix_oe_n = {SPI_OE_N[6:3], UART_OE_N, AUDIO_SERIAL_PORT2_OE_N,
                       GENERAL_PURPOSE_IO_LINE_OE_N[`SPM_GP_PP_BASE+5:`SPM_GP_PP_BASE],
                       SPI_OE_N[2:0]};

    // other parallel codes are outside this block: pins released, inputs low
    always @* begin
        PP_PIN_OUT  = 21'h000000;
        PP_PIN_OE_N = 21'h1fffff;
        DISP_IN     = 21'h000000;
        mix_in      = 21'h000000;
        case (parallel_port_select)
            `SPM_PP_DISP: begin
                PP_PIN_OUT  = DISP_OUT;
                PP_PIN_OE_N = DISP_OE_N;
                DISP_IN     = PP_PIN_IN;
            end
            `SPM_PP_MIXED: begin
                PP_PIN_OUT  = mix_out;
                PP_PIN_OE_N = mix_oe_n;
                mix_in      = PP_PIN_IN;
            end
            default: begin
                PP_PIN_OUT  = 21'h000000;
                PP_PIN_OE_N = 21'h1fffff;
            end
        endcase
    end

    assign SPI_IN                = {mix_in[20:17], mix_in[2:0]};
    assign UART_IN               = mix_in[16:13];
    assign AUDIO_SERIAL_PORT2_IN = mix_in[12:9];

    // lines with no pin here (18..20, 27..31) read low
    assign GENERAL_PURPOSE_IO_LINE_IN = {5'h00, addr_gpio_in, 3'h0, mix_in[8:3],
                                         sp1_gpio_in, sp0_gpio_in};

endmodule

//--- tb/spm_pin_mux_assertions.sv
`timescale 1ns/1ns
module spm_pin_mux_checker (
    input wire        REF_CLK,
    input wire        RSTN,
    input wire [7:0]  REG_ADDR,
    input wire [15:0] REG_WDATA,
    input wire        REG_WR,
    input wire        REG_RD,
    input wire [15:0] REG_RDATA,
    input wire [5:0]  SP1_PIN_IN,
    input wire [5:0]  SP1_PIN_OUT,
    input wire [5:0]  SP0_PIN_IN,
    input wire [5:0]  SP0_PIN_OUT,
    input wire [5:0]  CARD_PORT1_OUT,
    input wire [5:0]  CARD_PORT0_OUT,
    input wire [5:0]  CARD_PORT0_IN,
    input wire [3:0]  AUDIO_SERIAL_PORT1_OUT,
    input wire [3:0]  AUDIO_SERIAL_PORT0_OUT,
    input wire [5:0]  ADDR_PIN_OUT,
    input wire [5:0]  EXT_MEMORY_ADDRESS,
    input wire [20:0] PP_PIN_OUT,
    input wire [20:0] DISP_OUT,
    input wire [6:0]  SPI_OUT,
    input wire [3:0]  UART_OUT,
    input wire [3:0]  AUDIO_SERIAL_PORT2_OUT,
    input wire [31:0] GENERAL_PURPOSE_IO_LINE_OUT,
    input wire [31:0] GENERAL_PURPOSE_IO_LINE_IN
);
    reg  [15:0] sel;
    wire [31:0] go = GENERAL_PURPOSE_IO_LINE_OUT;
    wire [31:0] gi = GENERAL_PURPOSE_IO_LINE_IN;
    // shadow of the selection register, kept from the bus alone
    always @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN)
            sel <= 16'h0000;
        else if (REG_WR && REG_ADDR == 8'h00)
            sel <= REG_WDATA & 16'h7f3f;
    end
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    a_sp1_card: assert property (sel[11:10] == 2'h0 |-> SP1_PIN_OUT == CARD_PORT1_OUT)
        else $error("serial port 1 pins lost the card port");
    a_sp1_audio: assert property (
        sel[11:10] == 2'h1 |-> SP1_PIN_OUT == {go[11:10], AUDIO_SERIAL_PORT1_OUT})
        else $error("serial port 1 pins lost the audio port");
    a_sp1_gpio: assert property (
        sel[11:10] == 2'h2 |-> SP1_PIN_OUT == go[11:6] && gi[11:6] == SP1_PIN_IN)
        else $error("serial port 1 pins lost gpio 11 to 6");
    a_sp0_card: assert property (
        sel[9:8] == 2'h0 |-> SP0_PIN_OUT == CARD_PORT0_OUT && CARD_PORT0_IN == SP0_PIN_IN)
        else $error("serial port 0 pins lost the card port");
    a_sp0_audio: assert property (
        sel[9:8] == 2'h1 |-> SP0_PIN_OUT == {go[5:4], AUDIO_SERIAL_PORT0_OUT})
        else $error("serial port 0 pins lost the audio port");
    a_sp0_gpio: assert property (
        sel[9:8] == 2'h2 |-> SP0_PIN_OUT == go[5:0] && gi[5:0] == SP0_PIN_IN)
        else $error("serial port 0 pins lost gpio 5 to 0");
    a_sel_readback: assert property (
        REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == $past(sel))
        else $error("selection readback wrong or reserved bits set");
    a_addr_pins: assert property (
        ADDR_PIN_OUT == (sel[5:0] & go[26:21] | ~sel[5:0] & EXT_MEMORY_ADDRESS))
        else $error("address pin function wrong");
    a_pp_display: assert property (sel[14:12] == 3'h0 |-> PP_PIN_OUT == DISP_OUT)
        else $error("parallel pins lost the display bridge");
    a_pp_mixed: assert property (
        sel[14:12] == 3'h1 |-> PP_PIN_OUT == {SPI_OUT[6:3], UART_OUT, AUDIO_SERIAL_PORT2_OUT,
                                              go[17:12], SPI_OUT[2:0]})
        else $error("parallel pins mixed mode wrong");
    a_idle_card: assert property (sel[9:8] != 2'h0 |-> CARD_PORT0_IN == 6'h00)
        else $error("unselected card port 0 input not quiet");
endmodule

//--- tb/spm_far_side.sv
`timescale 1ns/1ns
// peripherals and board pins: every line toggles, so a stuck route cannot hide
module spm_far_side (
    input  wire         clk,
    input  wire         rstn,
    input  wire         periph_rst,
    output wire [220:0] drive
);
    reg [63:0] p;
    assign drive = {p[28:0], ~p, p[31:0], p[63:32], ~p[15:0], p[63:16]};
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            p <= 64'h0123456789abcdef;
        else if (periph_rst)
            p <= 64'h0123456789abcdef;
        else
            p <= {p[62:0], ~p[63]};
    end
endmodule

//--- tb/spm_pin_mux_bench.sv
`timescale 1ns/1ns
module spm_pin_mux_bench;
    reg          REF_CLK, RSTN, REG_WR, REG_RD, PERIPH_RST;
    reg  [7:0]   REG_ADDR;
    reg  [15:0]  REG_WDATA;
    wire [15:0]  REG_RDATA;
    wire [220:0] drive;
    wire [5:0]   SP1_PIN_IN, SP1_PIN_OUT, SP1_PIN_OE_N, SP0_PIN_IN, SP0_PIN_OUT, SP0_PIN_OE_N;
    wire [5:0]   CARD_PORT1_OUT, CARD_PORT1_OE_N, CARD_PORT1_IN, CARD_PORT0_OUT, CARD_PORT0_OE_N;
    wire [5:0]   CARD_PORT0_IN, ADDR_PIN_IN, ADDR_PIN_OUT, ADDR_PIN_OE_N, EXT_MEMORY_ADDRESS;
    wire [3:0]   AUDIO_SERIAL_PORT1_OUT, AUDIO_SERIAL_PORT1_OE_N, AUDIO_SERIAL_PORT1_IN;
    wire [3:0]   AUDIO_SERIAL_PORT0_OUT, AUDIO_SERIAL_PORT0_OE_N, AUDIO_SERIAL_PORT0_IN;
    wire [3:0]   AUDIO_SERIAL_PORT2_OUT, AUDIO_SERIAL_PORT2_OE_N, AUDIO_SERIAL_PORT2_IN;
    wire [3:0]   UART_OUT, UART_OE_N, UART_IN;
    wire [6:0]   SPI_OUT, SPI_OE_N, SPI_IN;
    wire [20:0]  PP_PIN_IN, PP_PIN_OUT, PP_PIN_OE_N, DISP_OUT, DISP_OE_N, DISP_IN;
    wire [31:0]  GENERAL_PURPOSE_IO_LINE_OUT, GENERAL_PURPOSE_IO_LINE_OE_N;
    wire [31:0]  GENERAL_PURPOSE_IO_LINE_IN;
    wire [31:0]  go = GENERAL_PURPOSE_IO_LINE_OUT;
    wire [31:0]  goe = GENERAL_PURPOSE_IO_LINE_OE_N;
    integer      failures, check_count, i;
    // write value beside the value it must read back
    localparam logic [31:0] ROWS [8] = '{32'h00000000, 32'h05000500, 32'h0a3f0a3f, 32'h0f150f15,
        32'h102a102a, 32'h24c02400, 32'hffff7f3f, 32'h00000000};
    assign {SP1_PIN_IN, SP0_PIN_IN, ADDR_PIN_IN, EXT_MEMORY_ADDRESS, PP_PIN_IN, DISP_OUT,
        DISP_OE_N, SPI_OUT, SPI_OE_N, CARD_PORT1_OUT, CARD_PORT1_OE_N, CARD_PORT0_OUT,
        CARD_PORT0_OE_N, AUDIO_SERIAL_PORT1_OUT, AUDIO_SERIAL_PORT1_OE_N, AUDIO_SERIAL_PORT0_OUT,
        AUDIO_SERIAL_PORT0_OE_N, UART_OUT, UART_OE_N, AUDIO_SERIAL_PORT2_OUT,
        AUDIO_SERIAL_PORT2_OE_N, GENERAL_PURPOSE_IO_LINE_OUT,
        GENERAL_PURPOSE_IO_LINE_OE_N} = drive;
    spm_pin_mux DUT (.*);
    spm_far_side far (.clk(REF_CLK), .rstn(RSTN), .periph_rst(PERIPH_RST), .drive(drive));
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // {pin out, pin oe_n, card in, audio in, gpio in}
    function [27:0] ser(input [1:0] m, input [5:0] c, co, input [3:0] a, ao,
                        input [5:0] gt, gte, pi);
        case (m)
            2'h0: ser = {c, co, pi, 4'h0, 6'h00};
            2'h1: ser = {gt[5:4], a, gte[5:4], ao, 6'h00, pi[3:0], pi[5:4], 4'h0};
            2'h2: ser = {gt, gte, 6'h00, 4'h0, pi};
            default: ser = {6'h00, 6'h3f, 16'h0000};
        endcase
    endfunction
    task cmp(input [150:0] g, input [150:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            REG_ADDR  <= a;
            REG_WDATA <= d;
            REG_WR    <= 1'b1;
            REG_RD    <= 1'b0;
            @(posedge REF_CLK);
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            REG_ADDR <= a;
            REG_WR   <= 1'b0;
            REG_RD   <= 1'b1;
            @(posedge REF_CLK);
            REG_RD <= 1'b0;
            @(negedge REF_CLK);
            cmp(REG_RDATA, e);
            @(posedge REF_CLK);
        end
    endtask
    // pins are combinational, so look at mid-cycle once the far side has settled
    task check_pins(input [15:0] s);
        reg [27:0] s1;
        reg [27:0] s0;
        reg [41:0] pp;
        reg [26:0] px;
        begin
            REG_WR     <= 1'b0;
            PERIPH_RST <= 1'b1;
            @(negedge REF_CLK);
            s1 = ser(s[11:10], CARD_PORT1_OUT, CARD_PORT1_OE_N, AUDIO_SERIAL_PORT1_OUT,
                     AUDIO_SERIAL_PORT1_OE_N, go[11:6], goe[11:6], SP1_PIN_IN);
            s0 = ser(s[9:8], CARD_PORT0_OUT, CARD_PORT0_OE_N, AUDIO_SERIAL_PORT0_OUT,
                     AUDIO_SERIAL_PORT0_OE_N, go[5:0], goe[5:0], SP0_PIN_IN);
            case (s[14:12])
                3'h0: {pp, px} = {DISP_OUT, DISP_OE_N, PP_PIN_IN, 6'h00};
                3'h1: {pp, px} = {SPI_OUT[6:3], UART_OUT, AUDIO_SERIAL_PORT2_OUT, go[17:12],
                    SPI_OUT[2:0], SPI_OE_N[6:3], UART_OE_N, AUDIO_SERIAL_PORT2_OE_N, goe[17:12],
                    SPI_OE_N[2:0], 21'h000000, PP_PIN_IN[8:3]};
                default: {pp, px} = {21'h000000, 21'h1fffff, 27'h0000000};
            endcase
            cmp({SP1_PIN_OUT, SP1_PIN_OE_N, SP0_PIN_OUT, SP0_PIN_OE_N, ADDR_PIN_OUT,
                 ADDR_PIN_OE_N, PP_PIN_OUT, PP_PIN_OE_N, CARD_PORT1_IN, CARD_PORT0_IN,
                 AUDIO_SERIAL_PORT1_IN, AUDIO_SERIAL_PORT0_IN, DISP_IN,
                 GENERAL_PURPOSE_IO_LINE_IN},
                {s1[27:16], s0[27:16], s[5:0] & go[26:21] | ~s[5:0] & EXT_MEMORY_ADDRESS,
                 s[5:0] & goe[26:21], pp, s1[15:10], s0[15:10], s1[9:6], s0[9:6], px[26:6],
                 5'h00, s[5:0] & ADDR_PIN_IN, 3'h0, px[5:0], s1[5:0], s0[5:0]});
            // shared peripheral inputs only see the parallel pins in mixed mode
            cmp({SPI_IN, UART_IN, AUDIO_SERIAL_PORT2_IN},
                (s[14:12] == 3'h1) ? {PP_PIN_IN[20:17], PP_PIN_IN[2:0], PP_PIN_IN[16:9]}
                                   : 15'h0000);
            @(posedge REF_CLK);
            PERIPH_RST <= 1'b0;
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial begin
        RSTN        = 1'b0;
        REG_WR      = 1'b0;
        REG_RD      = 1'b0;
        REG_ADDR    = 8'h00;
        REG_WDATA   = 16'h0000;
        PERIPH_RST  = 1'b0;
        failures    = 0;
        check_count = 0;
        repeat (6) @(posedge REF_CLK);
        RSTN <= 1'b1;
        check_pins(16'h0000);
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        $display("reset test done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(8'h00, ROWS[i][31:16]);
            check_pins(ROWS[i][15:0]);
            rd(8'h00, ROWS[i][15:0]);
        end
        $display("mode table done");
        // a read right behind the write sees the change flag
        wr(8'h01, 16'h000f);
        wr(8'h00, 16'h0100);
        rd(8'h01, 16'h0002);
        wr(8'h01, 16'h0002);
        rd(8'h01, 16'h0000);
        $display("change flag test done");
        wr(8'h7e, 16'h0a3f);
        rd(8'h7e, 16'h0000);
        check_pins(16'h0100);
        $display("unmapped test done");
        wr(8'h00, 16'h0a3f);
        RSTN <= 1'b0;
        check_pins(16'h0000);
        RSTN <= 1'b1;
        rd(8'h00, 16'h0000);
        $display("reset in mid-run done");
        wrap_up;
    end
endmodule
bind spm_pin_mux spm_pin_mux_checker chk (.*);
